// *** src/ppt_pkg.sv ***
// Contract
// - Data readback returns byte on parallel lines
// - Status upper five bits show printer inputs
// - Acknowledge input is printer handshake reply
// - Control readback returns present control outputs
// - Control write sets the four control lines and the gate bit
// - Gate bit enables the interrupt request output
// - Strobe output marks valid byte for printer
// - Data write drives byte onto parallel lines
package ppt_pkg;

  localparam int DATA_W      = 8;
  localparam int ADDR_W      = 2;

  // Register offsets on the processor port
  localparam logic [ADDR_W-1:0] OFF_DATA   = 2'h0;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 2'h1;
  localparam logic [ADDR_W-1:0] OFF_CTRL   = 2'h2;

  localparam logic [DATA_W-1:0] DATA_RST   = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_Q = 8'hff;

  // Status byte: five printer inputs in bits 7..3, zeros below
  typedef struct packed {
    logic       busy;
    logic       ack_n;
    logic       paper_out;
    logic       printer_selected;
    logic       error_n;
    logic [2:0] zero;
  } ppt_status_s;

  // Control byte: bits 7..5 read as zero
  typedef struct packed {
    logic [2:0] zero;
    logic       port_interrupt_gate;
    logic       select_input_line;
    logic       init;
    logic       paper_autoadvance;
    logic       strobe;
  } ppt_ctrl_s;

  localparam ppt_ctrl_s CTRL_RST = '{zero: 3'h0, default: 1'b0};

  // Processor-side pins sampled together
  typedef struct packed {
    logic              chip_sel_n;
    logic              io_read_strobe_n;
    logic              io_write_strobe_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } ppt_bus_s;

  localparam ppt_bus_s BUS_IDLE_PINS = '{
    chip_sel_n: 1'b1, io_read_strobe_n: 1'b1, io_write_strobe_n: 1'b1,
    addr: 2'h0, data: 8'h00};

  // Printer status pins idle: not busy, no ack, no error
  localparam ppt_status_s STATUS_IDLE_PINS = '{
    busy: 1'b0, ack_n: 1'b1, paper_out: 1'b0, printer_selected: 1'b0,
    error_n: 1'b1, zero: 3'h0};

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_READ,
    BUS_WRITE
  } ppt_bus_state_e;

endpackage : ppt_pkg

// *** src/ppt_top.sv ***
`timescale 1ns/1ps

module ppt_top #(
  parameter int DATA_W = ppt_pkg::DATA_W,
  parameter int ADDR_W = ppt_pkg::ADDR_W
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Processor port
  input  wire logic              io_chip_sel_n,
  input  wire logic              io_read_strobe_n,
  input  wire logic              io_write_strobe_n,
  input  wire logic [ADDR_W-1:0] io_addr,
  input  wire logic [DATA_W-1:0] db_in,
  output logic      [DATA_W-1:0] db_out,
  output logic                   db_oe,
  output logic                   printer_port_irq,
  // Printer port
  output logic      [DATA_W-1:0] pd_out,
  output logic                   strobe_n,
  output logic                   paper_autoadvance_n,
  output logic                   init_n,
  output logic                   select_input_line_n,
  input  wire logic              busy,
  input  wire logic              ack_n,
  input  wire logic              paper_out,
  input  wire logic              printer_selected,
  input  wire logic              error_n
);

  // ------------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------------
  // Address and data pass the same two stages as the strobes, so
  // they stay aligned with the strobe that qualifies them.
  ppt_pkg::ppt_bus_s    bus_pins;
  ppt_pkg::ppt_bus_s    bus_meta_r;
  ppt_pkg::ppt_bus_s    bus_meta_nxt;
  ppt_pkg::ppt_bus_s    bus_sync_r;
  ppt_pkg::ppt_bus_s    bus_sync_nxt;

  ppt_pkg::ppt_status_s st_pins;
  ppt_pkg::ppt_status_s st_meta_r;
  ppt_pkg::ppt_status_s st_meta_nxt;
  ppt_pkg::ppt_status_s st_sync_r;
  ppt_pkg::ppt_status_s st_sync_nxt;

  always_comb begin
    bus_pins.chip_sel_n        = io_chip_sel_n;
    bus_pins.io_read_strobe_n  = io_read_strobe_n;
    bus_pins.io_write_strobe_n = io_write_strobe_n;
    bus_pins.addr              = io_addr;
    bus_pins.data              = db_in;
  end

  always_comb begin
    st_pins.busy             = busy;
    st_pins.ack_n            = ack_n;
    st_pins.paper_out        = paper_out;
    st_pins.printer_selected = printer_selected;
    st_pins.error_n          = error_n;
    st_pins.zero             = 3'h0;
  end

  always_comb begin
    bus_meta_nxt = bus_pins;
    bus_sync_nxt = bus_meta_r;
    st_meta_nxt  = st_pins;
    st_sync_nxt  = st_meta_r;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // Idle levels, so no false access follows reset
      bus_meta_r <= ppt_pkg::BUS_IDLE_PINS;
      bus_sync_r <= ppt_pkg::BUS_IDLE_PINS;
      st_meta_r  <= ppt_pkg::STATUS_IDLE_PINS;
      st_sync_r  <= ppt_pkg::STATUS_IDLE_PINS;
    end else begin
      bus_meta_r <= bus_meta_nxt;
      bus_sync_r <= bus_sync_nxt;
      st_meta_r  <= st_meta_nxt;
      st_sync_r  <= st_sync_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Access decode
  // ------------------------------------------------------------------
  logic rd_req;
  logic wr_req;

  // A strobe counts only while the port is selected
  always_comb begin
    rd_req = !bus_sync_r.chip_sel_n && !bus_sync_r.io_read_strobe_n;
    wr_req = !bus_sync_r.chip_sel_n && !bus_sync_r.io_write_strobe_n;
  end

  // ------------------------------------------------------------------
  // Access sequencer: one write per strobe assertion
  // ------------------------------------------------------------------
  // A write strobe held for many cycles stores once, on its first
  // synchronised cycle; the strobe must fall back before the next.
  ppt_pkg::ppt_bus_state_e state_r;
  ppt_pkg::ppt_bus_state_e state_nxt;
  logic                    wr_fire;

  always_comb begin
    state_nxt = state_r;
    wr_fire   = 1'b0;
    case (state_r)
      ppt_pkg::BUS_IDLE: begin
        // Read wins a tie; the write is taken once the read has ended
        if (rd_req) begin
          state_nxt = ppt_pkg::BUS_READ;
        end else if (wr_req) begin
          state_nxt = ppt_pkg::BUS_WRITE;
          wr_fire   = 1'b1;
        end
      end
      ppt_pkg::BUS_READ: begin
        if (!rd_req) begin
          state_nxt = ppt_pkg::BUS_IDLE;
        end
      end
      ppt_pkg::BUS_WRITE: begin
        if (!wr_req) begin
          state_nxt = ppt_pkg::BUS_IDLE;
        end
      end
      default: begin
        state_nxt = ppt_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= ppt_pkg::BUS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Data output and control registers
  // ------------------------------------------------------------------
  logic [DATA_W-1:0]  data_r;
  logic [DATA_W-1:0]  data_nxt;
  ppt_pkg::ppt_ctrl_s ctrl_r;
  ppt_pkg::ppt_ctrl_s ctrl_nxt;

  always_comb begin
    data_nxt = data_r;
    ctrl_nxt = ctrl_r;
    if (wr_fire) begin
      case (bus_sync_r.addr)
        ppt_pkg::OFF_DATA: begin
          data_nxt = bus_sync_r.data;
        end
        ppt_pkg::OFF_CTRL: begin
          ctrl_nxt      = ppt_pkg::ppt_ctrl_s'(bus_sync_r.data);
          ctrl_nxt.zero = 3'h0;
        end
        default: begin
          // Status and unmapped offsets ignore writes
          data_nxt = data_r;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_r <= ppt_pkg::DATA_RST;
      ctrl_r <= ppt_pkg::CTRL_RST;
    end else begin
      data_r <= data_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------------
  // Read data is refreshed every cycle of the read, so a status
  // change during a long strobe is seen by the processor.
  logic [DATA_W-1:0] rd_data_r;
  logic [DATA_W-1:0] rd_data_nxt;
  logic              oe_r;
  logic              oe_nxt;

  always_comb begin
    oe_nxt      = (state_nxt == ppt_pkg::BUS_READ);
    rd_data_nxt = rd_data_r;
    if (oe_nxt) begin
      case (bus_sync_r.addr)
        ppt_pkg::OFF_DATA: begin
          rd_data_nxt = data_r;
        end
        ppt_pkg::OFF_STATUS: begin
          rd_data_nxt = st_sync_r;
        end
        ppt_pkg::OFF_CTRL: begin
          rd_data_nxt = ctrl_r;
        end
        default: begin
          // Nothing answers here; the bus reads all ones
          rd_data_nxt = ppt_pkg::UNMAPPED_Q;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data_r <= ppt_pkg::DATA_RST;
      oe_r      <= 1'b0;
    end else begin
      rd_data_r <= rd_data_nxt;
      oe_r      <= oe_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Interrupt request
  // ------------------------------------------------------------------
  // Follows the printer's acknowledge pulse; no latching, so a short
  // pulse shows as a short request.
  logic irq_r;
  logic irq_nxt;

  always_comb begin
    irq_nxt = ctrl_r.port_interrupt_gate && !st_sync_r.ack_n;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Control line drivers
  // ------------------------------------------------------------------
  // Each pin has a flop of its own, loaded from the next control value,
  // so the pins leave straight from flops and still move in the cycle
  // in which the control register does. Pins are active low; the
  // register keeps the asserted sense so the readback needs no inversion.
  localparam int CTRL_LINES = 4;

  ppt_pkg::ppt_ctrl_s    ctrl_rst_view;
  logic [CTRL_LINES-1:0] line_rst;
  logic [CTRL_LINES-1:0] line_nxt;
  logic [CTRL_LINES-1:0] pin_n_r;
  logic [CTRL_LINES-1:0] pin_n_nxt;

  // Reset levels follow the control register's reset value, so pins and
  // readback agree from the first cycle after reset.
  always_comb begin
    ctrl_rst_view = ppt_pkg::CTRL_RST;
    line_rst      = {ctrl_rst_view.select_input_line, ctrl_rst_view.init,
                     ctrl_rst_view.paper_autoadvance, ctrl_rst_view.strobe};
  end

  always_comb begin
    line_nxt = {ctrl_nxt.select_input_line, ctrl_nxt.init,
                ctrl_nxt.paper_autoadvance, ctrl_nxt.strobe};
  end

  for (genvar i = 0; i < CTRL_LINES; i++) begin : g_line
    always_comb begin
      pin_n_nxt[i] = !line_nxt[i];
    end

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        pin_n_r[i] <= !line_rst[i];
      end else begin
        pin_n_r[i] <= pin_n_nxt[i];
      end
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  // Every output leaves straight from a flop; the data bus is enabled
  // only while a read is in progress.
  always_comb begin
    db_out           = rd_data_r;
    db_oe            = oe_r;
    printer_port_irq = irq_r;
    pd_out           = data_r;
    {select_input_line_n, init_n,
     paper_autoadvance_n, strobe_n} = pin_n_r;
  end

endmodule : ppt_top

// *** dv/ppt_asserts.sv ***
`timescale 1ns/1ps
module ppt_asserts (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       io_chip_sel_n,
  input wire logic       io_read_strobe_n,
  input wire logic       io_write_strobe_n,
  input wire logic [1:0] io_addr,
  input wire logic [7:0] db_out,
  input wire logic       db_oe,
  input wire logic       printer_port_irq,
  input wire logic [7:0] pd_out,
  input wire logic       strobe_n,
  input wire logic       paper_autoadvance_n,
  input wire logic       init_n,
  input wire logic       select_input_line_n,
  input wire logic       ack_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic [3:0] pins;
  logic       rd_q;
  logic       wr_q;
  assign pins = {select_input_line_n, init_n, paper_autoadvance_n, strobe_n};
  assign rd_q = !io_read_strobe_n && !io_chip_sel_n;
  assign wr_q = !io_write_strobe_n && !io_chip_sel_n;
  // Three cycles: two sync flops plus the output register
  a_data_write: assert property (!$stable(pd_out) |-> $past(wr_q, 3)
    && $past(io_addr, 3) == ppt_pkg::OFF_DATA) else $error("pd_out moved");
  a_ctrl_write: assert property (!$stable(pins) |-> $past(wr_q, 3)
    && $past(io_addr, 3) == ppt_pkg::OFF_CTRL) else $error("ctrl moved");
  a_oe_cause: assert property (db_oe |-> $past(rd_q, 3))
    else $error("db_oe without read");
  a_oe_rise: assert property ($rose(rd_q) |-> ##3 db_oe)
    else $error("db_oe late");
  a_status_low: assert property (db_oe && $past(io_addr, 3) ==
    ppt_pkg::OFF_STATUS |-> db_out[2:0] == 3'h0) else $error("status low");
  a_unmapped_read: assert property (db_oe && $past(io_addr, 3) ==
    2'h3 |-> db_out == ppt_pkg::UNMAPPED_Q) else $error("offset 3");
  a_data_rdbk: assert property (db_oe && $past(io_addr, 3) ==
    ppt_pkg::OFF_DATA |-> db_out == pd_out) else $error("data readback");
  a_ctrl_rdbk: assert property (db_oe && $past(io_addr, 3) ==
    ppt_pkg::OFF_CTRL |-> db_out[3:0] == ~pins && db_out[7:5] == 3'h0)
    else $error("ctrl readback");
  a_irq_cause: assert property (printer_port_irq |-> !$past(ack_n, 3))
    else $error("irq without ack");
  c_read: cover property ($rose(db_oe));
  c_strobe: cover property ($fell(strobe_n));
  c_irq: cover property ($rose(printer_port_irq));
endmodule : ppt_asserts
bind ppt_top ppt_asserts u_chk (.clk(clk), .rst_n(rst_n),
  .io_chip_sel_n(io_chip_sel_n), .io_read_strobe_n(io_read_strobe_n),
  .io_write_strobe_n(io_write_strobe_n), .io_addr(io_addr),
  .db_out(db_out), .db_oe(db_oe), .printer_port_irq(printer_port_irq),
  .pd_out(pd_out), .strobe_n(strobe_n),
  .paper_autoadvance_n(paper_autoadvance_n), .init_n(init_n),
  .select_input_line_n(select_input_line_n), .ack_n(ack_n));

// *** dv/ppt_printer_model.sv ***
`timescale 1ns/1ps
module ppt_printer_model (
  input  wire logic       clk,
  input  wire logic [7:0] pd_out,
  input  wire logic       strobe_n,
  input  wire logic [2:0] cond,
  output logic            busy,
  output logic            ack_n,
  output logic            paper_out,
  output logic            printer_selected,
  output logic            error_n,
  output logic [7:0]      got_byte
);
  int   cnt = 0;
  logic strobe_q = 1'b1;
  // Lines always driven, never floating
  assign {paper_out, printer_selected, error_n} = cond;
  initial begin
    busy = 1'b0;
    ack_n = 1'b1;
    got_byte = 8'h00;
  end
  always @(posedge clk) begin
    strobe_q <= strobe_n;
    // Busy long enough for a status read; a new strobe restarts cleanly
    if (strobe_q && !strobe_n) begin
      got_byte <= pd_out;
      busy <= 1'b1;
      ack_n <= 1'b1;
      cnt <= 40;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      busy <= cnt > 20;
      ack_n <= !(cnt <= 20 && cnt > 1);
    end
  end
endmodule : ppt_printer_model

// *** dv/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic clk, rst_n, cs_n, rd_n, wr_n, db_oe, irq, strobe_n, auto_n, init_n;
  logic sel_n, busy, ack_n, pe, sel, err_n, oe;
  logic [1:0] addr;
  logic [2:0] cond;
  logic [7:0] db_in, db_out, pd_out, got, rv;
  int bad_count = 0;
  int checks_done = 0;
  ppt_top uut (.clk(clk), .rst_n(rst_n), .io_chip_sel_n(cs_n),
    .io_read_strobe_n(rd_n), .io_write_strobe_n(wr_n), .io_addr(addr),
    .db_in(db_in), .db_out(db_out), .db_oe(db_oe), .printer_port_irq(irq),
    .pd_out(pd_out), .strobe_n(strobe_n), .paper_autoadvance_n(auto_n),
    .init_n(init_n), .select_input_line_n(sel_n), .busy(busy),
    .ack_n(ack_n), .paper_out(pe), .printer_selected(sel), .error_n(err_n));
  ppt_printer_model prn (.clk(clk), .pd_out(pd_out), .strobe_n(strobe_n),
    .cond(cond), .busy(busy), .ack_n(ack_n), .paper_out(pe),
    .printer_selected(sel), .error_n(err_n), .got_byte(got));
  task automatic final_report;
    if (bad_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
      bad_count++;
    end
  endtask : chk
  // Strobe held 5 cycles, released 4: covers the sync latency
  task automatic acc(input logic w, input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    cs_n <= 1'b0;
    rd_n <= w;
    wr_n <= !w;
    addr <= a;
    db_in <= d;
    repeat (4) @(posedge clk);
    #1 rv = db_out;
    oe = db_oe;
    if (!w) chk({7'h0, oe}, 8'h01);
    @(posedge clk);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : acc
  task automatic t_data;
    acc(1, ppt_pkg::OFF_DATA, 8'h5a);
    chk(pd_out, 8'h5a);
    acc(0, ppt_pkg::OFF_DATA, 8'h00);
    chk(rv, 8'h5a);
    acc(1, ppt_pkg::OFF_DATA, 8'ha5);
    acc(1, ppt_pkg::OFF_STATUS, 8'h00);
    acc(1, 2'h3, 8'h00);
    acc(0, ppt_pkg::OFF_DATA, 8'h00);
    chk(rv, 8'ha5);
    acc(0, 2'h3, 8'h00);
    chk(rv, ppt_pkg::UNMAPPED_Q);
  endtask : t_data
  task automatic t_status(input logic [2:0] c, input logic [7:0] e);
    @(posedge clk);
    cond <= c;
    acc(0, ppt_pkg::OFF_STATUS, 8'h00);
    chk(rv, e);
  endtask : t_status
  task automatic t_ctrl;
    for (int i = 0; i < 5; i++) begin
      acc(1, ppt_pkg::OFF_CTRL, 8'h01 << i);
      acc(0, ppt_pkg::OFF_CTRL, 8'h00);
      chk(rv, 8'h01 << i);
      chk({4'h0, sel_n, init_n, auto_n, strobe_n}, ~(8'h01 << i) & 8'h0f);
    end
    acc(1, ppt_pkg::OFF_CTRL, 8'hff);
    acc(0, ppt_pkg::OFF_CTRL, 8'h00);
    chk(rv, 8'h1f);
    acc(1, ppt_pkg::OFF_CTRL, 8'h00);
  endtask : t_ctrl
  task automatic t_hand(input logic g, input logic [7:0] d);
    acc(1, ppt_pkg::OFF_DATA, d);
    acc(1, ppt_pkg::OFF_CTRL, {3'h0, g, 4'h1});
    acc(0, ppt_pkg::OFF_STATUS, 8'h00);
    chk(rv & 8'hc0, 8'hc0);
    for (int n = 0; n < 40 && ack_n; n++) @(posedge clk);
    if (ack_n !== 1'b0) begin
      bad_count++;
      final_report;
    end
    chk(got, d);
    repeat (3) @(posedge clk);
    #1 chk({7'h0, irq}, {7'h0, g});
    acc(0, ppt_pkg::OFF_STATUS, 8'h00);
    chk(rv & 8'hc0, 8'h00);
    acc(1, ppt_pkg::OFF_CTRL, {3'h0, g, 4'h0});
  endtask : t_hand
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    {cs_n, rd_n, wr_n} = 3'h7;
    addr = 2'h0;
    db_in = 8'h00;
    cond = 3'h3;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk({4'h0, sel_n, init_n, auto_n, strobe_n}, 8'h0f);
    chk(pd_out, ppt_pkg::DATA_RST);
    t_data;
    t_status(3'h6, 8'h70);
    t_status(3'h1, 8'h48);
    t_ctrl;
    t_hand(1'b1, 8'h3c);
    t_hand(1'b0, 8'hc3);
    final_report;
  end
endmodule : testbench
